// >>> rtl/ccder_pkg.sv
// Package for the coprocessor-0 configuration, debug and error register bank.
// Assumes a single core clock and an active-low asynchronous core reset.
package ccder_pkg;
   // ==================================================================
   // Register selectors (coprocessor-0 register numbers)
   localparam logic [4:0] SEL_CONFIG   = 5'h10;
   localparam logic [4:0] SEL_LINKED_LOAD_ADDRESS   = 5'h11;
   localparam logic [4:0] SEL_WATCH_LO = 5'h12;
   localparam logic [4:0] SEL_WATCH_HI = 5'h13;
   localparam logic [4:0] SEL_EXT_PTE_CONTEXT = 5'h14;
   localparam logic [4:0] SEL_PARITY_ERROR_STUB     = 5'h1a;
   localparam logic [4:0] SEL_CACHE_ERROR_STUB = 5'h1b;
   localparam logic [4:0] SEL_TAG_LO   = 5'h1c;
   localparam logic [4:0] SEL_TAG_HI   = 5'h1d;
   localparam logic [4:0] SEL_ERROR_RETURN_PC = 5'h1e;

   // ==================================================================
   // Configuration register field layout and fixed values
   localparam int CFG_EC_LSB  = 28;
   localparam int CFG_EP_LSB  = 24;
   localparam int CFG_AD_BIT  = 23;
   localparam int CFG_M16_BIT = 20;
   localparam int CFG_FX1_LSB = 17;
   localparam int CFG_BP_BIT  = 16;
   localparam int CFG_BE_BIT  = 15;
   localparam int CFG_FX2_LSB = 13;
   localparam int CFG_CS_BIT  = 12;
   localparam int CFG_IC_LSB  = 9;
   localparam int CFG_DC_LSB  = 6;
   localparam int CFG_IB_BIT  = 5;
   localparam int CFG_DB_BIT  = 4;
   localparam int CFG_K0_LSB  = 0;
   localparam logic [2:0] CFG_FX1_VAL  = 3'h4;
   localparam logic [1:0] CFG_FX2_VAL  = 2'h3;
   localparam logic       CFG_BE_VAL   = 1'b0;
   localparam logic       CFG_CS_VAL   = 1'b1;
   localparam logic [2:0] CFG_IC_VAL   = 3'h5;
   localparam logic [2:0] CFG_DC_VAL   = 3'h4;
   localparam logic [2:0] K0_UNCACHED  = 3'h2;
   localparam logic       BP_RESET_VAL = 1'b0;

   // ==================================================================
   // Extended context, watch and error return PC layout
   localparam int XC_VPN2_LSB = 4;
   localparam int XC_VPN2_W   = 29;
   localparam int XC_BASE_LSB = 33;
   localparam int VA_VPN2_LSB = 11;
   localparam int WLO_ADDR_LSB = 3;
   localparam int WLO_RD_BIT   = 1;
   localparam int WLO_WR_BIT   = 0;
   localparam int WHI_ADDR_W   = 4;
   localparam int XC_BASE_W    = 31;
   localparam int EPC_ISA_BIT  = 0;

   // ==================================================================
   // Carriers
   typedef struct packed {
      logic        we;
      logic [4:0]  sel;
      logic [63:0] data;
   } ccder_move_t;

   typedef enum logic [1:0] {
      ERR_COLD = 2'b00,
      ERR_SOFT = 2'b01,
      ERR_NMI  = 2'b10
   } ccder_err_kind_t;

   typedef struct packed {
      logic            valid;
      ccder_err_kind_t kind;
      logic [63:0]     pc;
      logic [63:0]     prev_pc;
      logic            in_slot;
      logic            compact;
   } ccder_err_t;
endpackage : ccder_pkg

// >>> rtl/ccder_regs.sv
// Coprocessor-0 configuration, linked-load, watch, extended context, error stub,
// cache tag and error return PC registers.
// Assumes core-side pipeline supplies move, exception and memory reference strobes.
// Behaviour
// [R1] Clock ratio read-only, strapped at reset
// [R2] Accelerate, write-back pattern, kseg0 fields writable
// [R3] Software writes write-back pattern as zero
// [R4] Software keeps accelerate bit at zero
// [R5] Compact flag read-only, strap sampled at reset
// [R6] Branch predict-off bit cleared by reset
// [R7] Endian flag always reads zero
// [R8] Cache size mode one, sizes five and four
// [R9] Refill length bits select 4 or 8
// [R10] Kseg0 code 010 uncached, others cached
// [R11] Family-variable bits, incl 14:13, fixed constants
// [R12] Linked-load address plain diagnostic storage
// [R13] Watched physical address raises watch exception
// [R14] Refill captures virtual address bits 39:11
// [R15] Page-table base only software written
// [R16] Parity and cache error plain storage
// [R17] Tag registers written by move and cache
// [R18] Error PC captures reset/NMI exception PC
// [R19] Delay-slot fault records preceding branch address
// [R20] Compact mode records ISA-mode bit
// [R21] Error level set blocks error PC overwrite
// [R22] No delay-slot indicator bit exists
// [R23] Cold reset sets error level bit
`timescale 1ns/10ps
module ccder_regs #(
   parameter int PADDR_W = 36,  // Physical address width
   parameter int VADDR_W = 40   // Virtual address width
) (
   input  wire logic                clk_sys,            // Core clock
   input  wire logic                resetn,             // Async reset, active low
   input  wire logic [2:0]          clock_ratio_strap,  // Ratio strap level
   input  wire logic                compact_isa_enable_pin, // Compact ISA strap
   input  wire ccder_pkg::ccder_move_t mv,              // Move-to-cp0 write
   input  wire logic                rd_en,              // Move-from-cp0 read
   input  wire logic [4:0]          rd_sel,             // Read register number
   output logic      [63:0]         rd_data,            // Read data
   input  wire logic                cache_tag_we,       // Cache op tag write
   input  wire logic [31:0]         cache_tag_lo_in,    // Tag low from cache
   input  wire logic [31:0]         cache_tag_hi_in,    // Tag high from cache
   input  wire logic                mem_ref,            // Load/store reference
   input  wire logic                mem_is_store,       // 1 store, 0 load
   input  wire logic [PADDR_W-1:0]  mem_paddr,          // Reference address
   output logic                     watch_exc,          // Watch exception pulse
   input  wire logic                tlb_refill,         // Refill exception
   input  wire logic [VADDR_W-1:0]  bad_vaddr,          // Faulting address
   input  wire ccder_pkg::ccder_err_t err,              // Error exception
   input  wire logic                erl_clear,          // Clear error level
   output logic                     error_level_bit,    // Error level
   output logic                     branch_predict_off, // Prediction off
   output logic                     kseg0_uncached,     // Kseg0 uncached
   output logic                     instr_refill_len,   // I refill 8 words
   output logic                     data_refill_len,    // D refill 8 words
   output logic      [2:0]          clock_ratio_field,  // System clock ratio
   output logic                     compact_isa_flag    // Compact ISA enabled
);
   import ccder_pkg::*;

   // Watch compare assumes a four-bit high address part
   if (PADDR_W != 36 || VADDR_W < 40 || VADDR_W > 64) begin : g_bad_widths
      $error("ccder_regs: unsupported address widths");
   end

   // ==================================================================
   // Straps
   logic strap_taken_reg;
   logic [2:0] clock_ratio_field_reg;
   logic compact_isa_flag_reg;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         strap_taken_reg <= 1'b0;
      end else begin
         strap_taken_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         clock_ratio_field_reg <= 3'h0;
         compact_isa_flag_reg  <= 1'b0;
      end else if (!strap_taken_reg) begin
         clock_ratio_field_reg <= clock_ratio_strap;      // [R1]
         compact_isa_flag_reg  <= compact_isa_enable_pin; // [R5]
      end
   end

   // ==================================================================
   // Configuration register
   logic [3:0] writeback_pattern_field_reg;
   logic       accel_data_reg;
   logic       branch_predict_off_reg;
   logic       instr_refill_len_reg;
   logic       data_refill_len_reg;
   logic [2:0] kseg0_cache_mode_reg;
   logic       kseg0_uncached_reg;
   logic       cfg_we;

   assign cfg_we = mv.we && mv.sel == SEL_CONFIG;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         writeback_pattern_field_reg <= 4'h0;
         accel_data_reg              <= 1'b0;
         branch_predict_off_reg      <= BP_RESET_VAL; // [R6]
         instr_refill_len_reg        <= 1'b0;
         data_refill_len_reg         <= 1'b0;
         kseg0_cache_mode_reg        <= 3'h0;
      end else if (cfg_we) begin
         writeback_pattern_field_reg <= mv.data[CFG_EP_LSB +: 4]; // [R2]
         accel_data_reg              <= mv.data[CFG_AD_BIT];      // [R2]
         branch_predict_off_reg      <= mv.data[CFG_BP_BIT];
         instr_refill_len_reg        <= mv.data[CFG_IB_BIT];      // [R9]
         data_refill_len_reg         <= mv.data[CFG_DB_BIT];      // [R9]
         kseg0_cache_mode_reg        <= mv.data[CFG_K0_LSB +: 3]; // [R2]
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         kseg0_uncached_reg <= 1'b0;
      end else begin
         kseg0_uncached_reg <= (kseg0_cache_mode_reg == K0_UNCACHED); // [R10]
      end
   end

   logic [31:0] cfg_value;
   always_comb begin
      cfg_value = 32'h0;
      cfg_value[CFG_EC_LSB +: 3]  = clock_ratio_field_reg;
      cfg_value[CFG_EP_LSB +: 4]  = writeback_pattern_field_reg;
      cfg_value[CFG_AD_BIT]       = accel_data_reg;
      cfg_value[CFG_M16_BIT]      = compact_isa_flag_reg;
      cfg_value[CFG_FX1_LSB +: 3] = CFG_FX1_VAL;          // [R11]
      cfg_value[CFG_BP_BIT]       = branch_predict_off_reg;
      cfg_value[CFG_BE_BIT]       = CFG_BE_VAL;           // [R7]
      cfg_value[CFG_FX2_LSB +: 2] = CFG_FX2_VAL;          // [R11]
      cfg_value[CFG_CS_BIT]       = CFG_CS_VAL;           // [R8]
      cfg_value[CFG_IC_LSB +: 3]  = CFG_IC_VAL;           // [R8]
      cfg_value[CFG_DC_LSB +: 3]  = CFG_DC_VAL;           // [R8]
      cfg_value[CFG_IB_BIT]       = instr_refill_len_reg;
      cfg_value[CFG_DB_BIT]       = data_refill_len_reg;
      cfg_value[CFG_K0_LSB +: 3]  = kseg0_cache_mode_reg;
   end

   // ==================================================================
   // Plain storage registers
   logic [31:0] linked_load_address_reg;
   logic [31:0] parity_error_stub_reg;
   logic [31:0] cache_error_stub_reg;
   logic [31:0] cache_tag_low_reg;
   logic [31:0] cache_tag_high_reg;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         linked_load_address_reg <= 32'h0;
         parity_error_stub_reg   <= 32'h0;
         cache_error_stub_reg    <= 32'h0;
      end else if (mv.we) begin
         if (mv.sel == SEL_LINKED_LOAD_ADDRESS) begin
            linked_load_address_reg <= mv.data[31:0]; // [R12]
         end
         if (mv.sel == SEL_PARITY_ERROR_STUB) begin
            parity_error_stub_reg <= mv.data[31:0];   // [R16]
         end
         if (mv.sel == SEL_CACHE_ERROR_STUB) begin
            cache_error_stub_reg <= mv.data[31:0];    // [R16]
         end
      end
   end

   // Cache op write takes precedence over a move in the same cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cache_tag_low_reg  <= 32'h0;
         cache_tag_high_reg <= 32'h0;
      end else if (cache_tag_we) begin
         cache_tag_low_reg  <= cache_tag_lo_in; // [R17]
         cache_tag_high_reg <= cache_tag_hi_in; // [R17]
      end else if (mv.we && mv.sel == SEL_TAG_LO) begin
         cache_tag_low_reg <= mv.data[31:0];    // [R17]
      end else if (mv.we && mv.sel == SEL_TAG_HI) begin
         cache_tag_high_reg <= mv.data[31:0];   // [R17]
      end
   end

   // ==================================================================
   // Watch registers and comparator
   logic [31:0]           watch_address_low_reg;
   logic [WHI_ADDR_W-1:0] watch_address_high_reg;
   logic                  watch_exc_reg;
   logic                  watch_hit;
   logic                  watch_kind_ok;
   logic [PADDR_W-WLO_ADDR_LSB-1:0] watch_match_addr;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         watch_address_low_reg  <= 32'h0;
         watch_address_high_reg <= 4'h0;
      end else if (mv.we && mv.sel == SEL_WATCH_LO) begin
         watch_address_low_reg <= mv.data[31:0];
      end else if (mv.we && mv.sel == SEL_WATCH_HI) begin
         watch_address_high_reg <= mv.data[WHI_ADDR_W-1:0];
      end
   end

   // Hit needs the enable bit that matches the access kind
   assign watch_match_addr = {watch_address_high_reg, watch_address_low_reg[31:WLO_ADDR_LSB]};
   assign watch_kind_ok    = mem_is_store ? watch_address_low_reg[WLO_WR_BIT]
                                          : watch_address_low_reg[WLO_RD_BIT];
   assign watch_hit        = mem_ref && watch_kind_ok
      && mem_paddr[PADDR_W-1:WLO_ADDR_LSB] == watch_match_addr; // [R13]

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         watch_exc_reg <= 1'b0;
      end else begin
         watch_exc_reg <= watch_hit; // [R13]
      end
   end

   a_watch_load : assert property (@(posedge clk_sys) disable iff (!resetn) // [R13]
      mem_ref && !mem_is_store && watch_address_low_reg[WLO_RD_BIT]
      && mem_paddr[PADDR_W-1:WLO_ADDR_LSB]
         == {watch_address_high_reg, watch_address_low_reg[31:WLO_ADDR_LSB]}
      |=> watch_exc_reg)
      else $error("load to watched address raised no watch exception");

   // ==================================================================
   // Extended page-table context
   logic [XC_BASE_W-1:0] page_table_base_field_reg;
   logic [XC_VPN2_W-1:0] faulting_page_pair_field_reg;
   logic [XC_VPN2_W-1:0] bad_vpn2;
   logic [63:0]          ext_pte_context;

   assign bad_vpn2 = bad_vaddr[VA_VPN2_LSB +: XC_VPN2_W];

   // The base field is never touched by hardware
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         page_table_base_field_reg <= '0;
      end else if (mv.we && mv.sel == SEL_EXT_PTE_CONTEXT) begin
         page_table_base_field_reg <= mv.data[XC_BASE_LSB +: XC_BASE_W]; // [R15]
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         faulting_page_pair_field_reg <= '0;
      end else if (tlb_refill) begin
         faulting_page_pair_field_reg <= bad_vpn2; // [R14]
      end
   end

   assign ext_pte_context = {page_table_base_field_reg, faulting_page_pair_field_reg,
                             XC_VPN2_LSB'(1'b0)};

   a_refill_capture : assert property (@(posedge clk_sys) disable iff (!resetn) // [R14]
      tlb_refill |=> faulting_page_pair_field_reg == $past(bad_vpn2))
      else $error("refill did not capture the faulting page pair");

   // ==================================================================
   // Error level and error return PC
   logic        error_level_bit_reg;
   logic        error_isa_mode_bit;
   logic        err_seen;
   logic        err_take;
   logic [63:0] error_return_pc_reg;
   logic [63:0] epc_capture;

   assign err_seen           = err.valid && err.kind inside {ERR_COLD, ERR_SOFT, ERR_NMI};
   assign err_take           = err_seen && !error_level_bit_reg; // [R21]
   assign error_isa_mode_bit = err.compact;

   // A new error exception sets the level even when a clear comes with it
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         error_level_bit_reg <= 1'b1; // [R23]
      end else if (err_seen) begin
         error_level_bit_reg <= 1'b1;
      end else if (erl_clear) begin
         error_level_bit_reg <= 1'b0;
      end
   end

   // Delay slot and second half of an extend both resume at the leading instruction
   always_comb begin
      epc_capture = err.in_slot ? err.prev_pc : err.pc; // [R19]
      if (compact_isa_flag_reg) begin
         epc_capture[EPC_ISA_BIT] = error_isa_mode_bit; // [R20]
      end
   end

   // The captured address is the only trace of a delay-slot fault
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         error_return_pc_reg <= 64'h0;
      end else if (err_take) begin
         error_return_pc_reg <= epc_capture; // [R18] [R22]
      end else if (mv.we && mv.sel == SEL_ERROR_RETURN_PC) begin
         error_return_pc_reg <= mv.data;
      end
   end

   a_epc_erl_hold : assert property (@(posedge clk_sys) disable iff (!resetn) // [R21]
      error_level_bit_reg && !(mv.we && mv.sel == SEL_ERROR_RETURN_PC)
      |=> $stable(error_return_pc_reg))
      else $error("error return PC changed while error level set");

   a_epc_capture : assert property (@(posedge clk_sys) disable iff (!resetn) // [R18]
      err_seen && !error_level_bit_reg && !err.in_slot && !compact_isa_flag_reg
      |=> error_return_pc_reg == $past(err.pc))
      else $error("error exception PC not captured");

   a_cold_erl : assert property (@(posedge clk_sys) disable iff (!resetn) // [R23]
      !strap_taken_reg |-> error_level_bit_reg)
      else $error("error level not set after reset");

   // ==================================================================
   // Read port
   logic [63:0] rd_mux;
   logic [63:0] rd_data_reg;

   always_comb begin
      rd_mux = 64'h0;
      case (rd_sel)
         SEL_CONFIG:   rd_mux = 64'(cfg_value);
         SEL_LINKED_LOAD_ADDRESS:   rd_mux = 64'(linked_load_address_reg);
         SEL_WATCH_LO: rd_mux = 64'(watch_address_low_reg);
         SEL_WATCH_HI: rd_mux = 64'(watch_address_high_reg);
         SEL_EXT_PTE_CONTEXT: rd_mux = ext_pte_context;
         SEL_PARITY_ERROR_STUB:     rd_mux = 64'(parity_error_stub_reg);
         SEL_CACHE_ERROR_STUB: rd_mux = 64'(cache_error_stub_reg);
         SEL_TAG_LO:   rd_mux = 64'(cache_tag_low_reg);
         SEL_TAG_HI:   rd_mux = 64'(cache_tag_high_reg);
         SEL_ERROR_RETURN_PC: rd_mux = error_return_pc_reg;
         default:      rd_mux = 64'h0;
      endcase
   end

   // Read data holds until the next read
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_data_reg <= 64'h0;
      end else if (rd_en) begin
         rd_data_reg <= rd_mux;
      end
   end

   // ==================================================================
   // Strap, configuration and stub assertions
   a_ratio_stable : assert property (@(posedge clk_sys) disable iff (!resetn) // [R1]
      strap_taken_reg |=> $stable(clock_ratio_field_reg))
      else $error("clock ratio changed after reset");

   a_bp_reset : assert property (@(posedge clk_sys) disable iff (!resetn) // [R6]
      !strap_taken_reg |-> !branch_predict_off_reg)
      else $error("branch prediction not enabled after reset");

   a_k0_decode : assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
      kseg0_uncached_reg == ($past(kseg0_cache_mode_reg) == K0_UNCACHED))
      else $error("kseg0 uncached flag does not match the mode");

   a_stub_hold : assert property (@(posedge clk_sys) disable iff (!resetn) // [R16]
      !(mv.we && mv.sel == SEL_PARITY_ERROR_STUB) |=> $stable(parity_error_stub_reg))
      else $error("parity error stub changed without a move");

   // ==================================================================
   // Outputs
   assign rd_data            = rd_data_reg;
   assign watch_exc          = watch_exc_reg;
   assign error_level_bit    = error_level_bit_reg;
   assign branch_predict_off = branch_predict_off_reg;
   assign kseg0_uncached     = kseg0_uncached_reg;
   assign instr_refill_len   = instr_refill_len_reg;
   assign data_refill_len    = data_refill_len_reg;
   assign clock_ratio_field  = clock_ratio_field_reg;
   assign compact_isa_flag   = compact_isa_flag_reg;
endmodule : ccder_regs

// >>> sim/ccder_regs_tb.sv
// Self-checking testbench for the cp0 configuration, debug and error register bank.
// Assumes ccder_pkg and ccder_regs are compiled first; inputs change on falling edges.
`timescale 1ns/10ps
module ccder_regs_tb;
   import ccder_pkg::*;
   // ==================================================================
   // Stimulus and observed signals
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic [2:0]  clock_ratio_strap = 3'h1;
   logic        compact_isa_enable_pin = 1'b0;
   ccder_move_t mv = '0;
   logic        rd_en = 1'b0;
   logic [4:0]  rd_sel = 5'h0;
   logic        cache_tag_we = 1'b0;
   logic [31:0] cache_tag_lo_in = 32'h0;
   logic [31:0] cache_tag_hi_in = 32'h0;
   logic        mem_ref = 1'b0;
   logic        mem_is_store = 1'b0;
   logic [35:0] mem_paddr = 36'h0;
   logic        tlb_refill = 1'b0;
   logic [39:0] bad_vaddr = 40'h0;
   ccder_err_t  err = '0;
   logic        erl_clear = 1'b0;
   logic [63:0] rd_data;
   logic [2:0]  clock_ratio_field;
   logic        watch_exc, error_level_bit, branch_predict_off, kseg0_uncached;
   logic        instr_refill_len, data_refill_len, compact_isa_flag;
   int          errors = 0;
   int          checks_done = 0;
   logic [63:0] v;
   logic        hit;
   logic [2:0]  codes [5] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6};
   logic [4:0]  sels [5] = '{SEL_LINKED_LOAD_ADDRESS, SEL_PARITY_ERROR_STUB, SEL_CACHE_ERROR_STUB, SEL_TAG_LO, SEL_TAG_HI};

   always #2.5 clk_sys = ~clk_sys;

   ccder_regs dut_u (.clk_sys, .resetn, .clock_ratio_strap, .compact_isa_enable_pin, .mv,
      .rd_en, .rd_sel, .rd_data, .cache_tag_we, .cache_tag_lo_in, .cache_tag_hi_in,
      .mem_ref, .mem_is_store, .mem_paddr, .watch_exc, .tlb_refill, .bad_vaddr, .err,
      .erl_clear, .error_level_bit, .branch_predict_off, .kseg0_uncached,
      .instr_refill_len, .data_refill_len, .clock_ratio_field, .compact_isa_flag);

   // ==================================================================
   // Access tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   task automatic do_reset;
      resetn = 1'b0;
      repeat (12) @(negedge clk_sys);
      resetn = 1'b1;
      @(negedge clk_sys);
   endtask : do_reset

   task automatic wr(input logic [4:0] s, input logic [63:0] d);
      mv = '{we: 1'b1, sel: s, data: d};
      @(negedge clk_sys);
      mv.we = 1'b0;
      @(negedge clk_sys);
   endtask : wr

   task automatic rd(input logic [4:0] s);
      rd_en = 1'b1;
      rd_sel = s;
      @(negedge clk_sys);
      v = rd_data;
      rd_en = 1'b0;
      @(negedge clk_sys);
   endtask : rd

   // Watch hit may be combinational or registered, so look for three cycles
   task automatic probe(input logic [35:0] a, input logic st);
      mem_ref = 1'b1;
      mem_is_store = st;
      mem_paddr = a;
      @(negedge clk_sys);
      hit = watch_exc;
      mem_ref = 1'b0;
      repeat (2) begin
         @(negedge clk_sys);
         hit = hit | watch_exc;
      end
   endtask : probe

   task automatic raise_err(input ccder_err_kind_t k, input logic slot, input logic c);
      err = '{valid: 1'b1, kind: k, pc: 64'hffff_ffff_bfc0_0100,
              prev_pc: 64'hffff_ffff_8000_0ff8, in_slot: slot, compact: c};
      @(negedge clk_sys);
      err.valid = 1'b0;
   endtask : raise_err

   task automatic clear_erl;
      erl_clear = 1'b1;
      @(negedge clk_sys);
      erl_clear = 1'b0;
   endtask : clear_erl

   // ==================================================================
   // Scenarios
   initial begin
      for (int i = 0; i < 5; i++) begin
         clock_ratio_strap = codes[i];
         compact_isa_enable_pin = i[0];
         do_reset();
         check(64'(error_level_bit), 64'h1);
         rd(SEL_CONFIG);
         check(64'(v[30:28]), 64'(codes[i]));
         check(64'(clock_ratio_field), 64'(codes[i]));
         check(64'({v[20], compact_isa_flag}), {62'h0, i[0], i[0]});
         check(64'({v[16], branch_predict_off}), 64'h0);
         check(64'({v[19:17], v[15:6]}), 64'h11ec);
      end
      clock_ratio_strap = 3'h7;
      wr(SEL_CONFIG, 64'h7001_0032);
      rd(SEL_CONFIG);
      check(64'(v[30:28]), 64'h6);
      check(64'({v[27:23], v[16], v[5:0]}), 64'h72);
      check(64'({branch_predict_off, instr_refill_len, data_refill_len}), 64'h7);
      for (int k = 0; k < 8; k++) begin
         wr(SEL_CONFIG, 64'(k));
         check(64'(kseg0_uncached), 64'(k == 2));
         check(64'({branch_predict_off, instr_refill_len, data_refill_len}), 64'h0);
      end
      for (int i = 0; i < 5; i++) begin
         wr(sels[i], 64'(32'ha5c3_0f10 + i));
         rd(sels[i]);
         check(64'(v[31:0]), 64'(32'ha5c3_0f10 + i));
      end
      cache_tag_we = 1'b1;
      cache_tag_lo_in = 32'h1357_9bdf;
      cache_tag_hi_in = 32'h2468_ace0;
      @(negedge clk_sys);
      cache_tag_we = 1'b0;
      rd(SEL_TAG_LO);
      check(64'(v[31:0]), 64'h1357_9bdf);
      rd(SEL_TAG_HI);
      check(64'(v[31:0]), 64'h2468_ace0);
      wr(SEL_WATCH_LO, 64'h1234_567b);
      wr(SEL_WATCH_HI, 64'h9);
      probe(36'h9_1234_5678, 1'b0);
      check(64'(hit), 64'h1);
      probe(36'h9_1234_5678, 1'b1);
      check(64'(hit), 64'h1);
      probe(36'h9_1234_5680, 1'b0);
      check(64'(hit), 64'h0);
      wr(SEL_WATCH_LO, 64'h1234_567a);
      probe(36'h9_1234_5678, 1'b1);
      check(64'(hit), 64'h0);
      wr(SEL_EXT_PTE_CONTEXT, {31'h2aaa_aaaa, 33'h0});
      tlb_refill = 1'b1;
      bad_vaddr = 40'hc3_5a5a_5c00;
      @(negedge clk_sys);
      tlb_refill = 1'b0;
      rd(SEL_EXT_PTE_CONTEXT);
      check(64'(v[32:4]), 64'(bad_vaddr[39:11]));
      check(64'(v[63:33]), 64'h2aaa_aaaa);
      raise_err(ERR_NMI, 1'b0, 1'b0);
      rd(SEL_ERROR_RETURN_PC);
      check(64'(v === 64'hffff_ffff_bfc0_0100), 64'h0);
      clear_erl();
      check(64'(error_level_bit), 64'h0);
      raise_err(ERR_SOFT, 1'b1, 1'b0);
      rd(SEL_ERROR_RETURN_PC);
      check(v, 64'hffff_ffff_8000_0ff8);
      clear_erl();
      raise_err(ERR_COLD, 1'b0, 1'b0);
      rd(SEL_ERROR_RETURN_PC);
      check(v, 64'hffff_ffff_bfc0_0100);
      compact_isa_enable_pin = 1'b1;
      do_reset();
      check(64'(error_level_bit), 64'h1);
      clear_erl();
      raise_err(ERR_NMI, 1'b1, 1'b1);
      rd(SEL_ERROR_RETURN_PC);
      check(v, 64'hffff_ffff_8000_0ff9);
      end_sim();
   end
endmodule : ccder_regs_tb
